// File: hw/exec_map.svh
// Opcode, field and timing constants of the execute block
`ifndef EXEC_MAP_SVH
`define EXEC_MAP_SVH
`define OP_SPECIAL 6'h00
`define OP_COPZ 4'h4
`define OP_ORI 6'h0d
`define OP_SB 6'h28
`define OP_SH 6'h29
`define OP_LWR 6'h26
`define FN_SLL 6'h00
`define FN_READ_UPPER_PRODUCT 6'h10
`define FN_WRITE_UPPER_PRODUCT 6'h11
`define FN_READ_BOTTOM_PRODUCT 6'h12
`define FN_WRITE_BOTTOM_PRODUCT 6'h13
`define FN_SIGNED_PRODUCT_OP 6'h18
`define FN_UNSIGNED_PRODUCT_OP 6'h19
`define FN_DIV 6'h1a
`define FN_UNSIGNED_QUOTIENT_OP 6'h1b
`define FN_OR 6'h25
`define FN_NOR 6'h27
`define SUB_MF 5'h00
`define SUB_MT 5'h04
`define COP_RESERVED 2'h3
`define LOW_ZERO_BITS 11
`define BYTE_SHIFT 8
`define PRODUCT_HAZARD 2
`define PRODUCT_RESET 32'h0000_0000
`endif

// File: hw/exec_pkg.sv
// Types shared by the execute block and its product unit
package exec_pkg;
  typedef enum logic [2:0] {
    acc_none,
    acc_byte,
    acc_half,
    acc_lwr
  } mem_access_e;
  typedef enum logic [1:0] {
    exc_none,
    exc_cop_unusable,
    exc_reserved,
    exc_address
  } exc_code_e;
  typedef struct packed {
    logic signed_product_op_s;
    logic signed_product_op_u;
    logic wr_hi;
    logic wr_lo;
    logic rd_any;
    logic other_writer;
  } product_cmd_s;
endpackage

// File: hw/product_if.sv
// Commands and results between the decoder and the product unit
interface product_if;
  import exec_pkg::*;
  product_cmd_s cmd;
  logic [31:0] op_a;
  logic [31:0] op_b;
  logic [31:0] upper;
  logic [31:0] bottom;
  logic result_undefined;
  modport decoder (output cmd, output op_a, output op_b,
                   input upper, input bottom, input result_undefined);
  modport unit (input cmd, input op_a, input op_b,
                output upper, output bottom, output result_undefined);
endinterface

// File: hw/product_unit.sv
// Product register pair with multiply and direct writes
`include "exec_map.svh"
module product_unit (
  input wire logic core_clk,
  input wire logic reset_n,
  product_if.unit pif
);
  import exec_pkg::*;
  logic [31:0] upper;
  logic [31:0] bottom;
  logic [1:0] read_age;
  logic pending_signed_product_op;
  logic undef;
  logic [63:0] prod_s;
  logic [63:0] prod_u;
  logic any_signed_product_op;
  logic recent_read;
  assign prod_s = 64'($signed(pif.op_a) * $signed(pif.op_b));
  assign prod_u = 64'(pif.op_a * pif.op_b);
  assign any_signed_product_op = pif.cmd.signed_product_op_s | pif.cmd.signed_product_op_u;
  assign recent_read = read_age != 2'h0;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      upper <= `PRODUCT_RESET;
      bottom <= `PRODUCT_RESET;
    end else if (pif.cmd.signed_product_op_s) begin
      upper <= prod_s[63:32];
      bottom <= prod_s[31:0];
    end else if (pif.cmd.signed_product_op_u) begin
      upper <= prod_u[63:32];
      bottom <= prod_u[31:0];
    end else if (pif.cmd.wr_hi) begin
      upper <= pif.op_a;
    end else if (pif.cmd.wr_lo) begin
      bottom <= pif.op_a;
    end
  end
  // Reads within two slots spoil a multiply; direct write after multiply spoils companion
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      read_age <= 2'h0;
      pending_signed_product_op <= 1'b0;
      undef <= 1'b0;
    end else begin
      read_age <= pif.cmd.rd_any ? 2'(`PRODUCT_HAZARD) : (recent_read ? read_age - 2'h1 : 2'h0);
      if (any_signed_product_op) begin
        pending_signed_product_op <= ~pif.cmd.other_writer;
        undef <= recent_read;
      end else if (pif.cmd.rd_any) begin
        pending_signed_product_op <= 1'b0;
      end else if (pif.cmd.wr_hi | pif.cmd.wr_lo) begin
        undef <= pending_signed_product_op;
        pending_signed_product_op <= 1'b0;
      end else if (pif.cmd.other_writer) begin
        pending_signed_product_op <= 1'b1;
      end
    end
  end
  assign pif.upper = upper;
  assign pif.bottom = bottom;
  assign pif.result_undefined = undef;
endmodule

// File: hw/exec_unit.sv
// Decoder and executor for moves, multiply, logic, narrow stores and shift
`include "exec_map.svh"
module exec_unit (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic instr_valid,
  input wire logic [31:0] instr,
  input wire logic [31:0] primary_val,
  input wire logic [31:0] secondary_val,
  input wire logic [3:0] cop_usable,
  input wire logic [31:0] cop_read_data,
  input wire logic cpu_byte_order_big,
  input wire logic user_order_flip,
  input wire logic memory_byte_order_big,
  input wire logic [31:0] phys_addr,
  input wire logic tlb_refill,
  input wire logic tlb_invalid,
  input wire logic tlb_modified,
  input wire logic bus_error,
  input wire logic [31:0] load_data,
  output logic [31:0] virt_addr,
  output logic [1:0] cop_unit,
  output logic [4:0] cop_reg,
  output logic cop_read,
  output logic cop_write,
  output logic [31:0] cop_write_data,
  output logic gpr_we,
  output logic [4:0] gpr_addr,
  output logic [31:0] gpr_data,
  output logic mem_req,
  output logic mem_write,
  output exec_pkg::mem_access_e mem_access,
  output logic [1:0] mem_type,
  output logic [2:0] mem_addr_low,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  output logic [3:0] mem_lanes,
  output logic exc_valid,
  output exec_pkg::exc_code_e exc_code,
  output logic exc_tlb_refill,
  output logic exc_tlb_invalid,
  output logic exc_tlb_mod,
  output logic exc_bus,
  output logic product_undefined
);
  import exec_pkg::*;
  product_if pif ();
  product_unit prod (.core_clk(core_clk), .reset_n(reset_n), .pif(pif));

  wire [5:0] opcode = instr[31:26];
  wire [4:0] f_rs = instr[25:21];
  wire [4:0] f_rt = instr[20:16];
  wire [4:0] f_rd = instr[15:11];
  wire [4:0] f_sa = instr[10:6];
  wire [5:0] funct = instr[5:0];
  wire [15:0] imm = instr[15:0];
  wire [1:0] unit_no = instr[27:26];
  wire is_special = instr_valid && opcode == `OP_SPECIAL;
  wire is_copz = instr_valid && opcode[5:2] == `OP_COPZ;
  wire low_clear = instr[`LOW_ZERO_BITS-1:0] == 11'h000;
  wire is_mfc = is_copz && f_rs == `SUB_MF && low_clear;
  wire is_mtc = is_copz && f_rs == `SUB_MT && low_clear;
  wire unit_ok = cop_usable[unit_no];
  wire is_read_upper_product = is_special && funct == `FN_READ_UPPER_PRODUCT;
  wire is_read_bottom_product = is_special && funct == `FN_READ_BOTTOM_PRODUCT;
  wire is_write_upper_product = is_special && funct == `FN_WRITE_UPPER_PRODUCT;
  wire is_write_bottom_product = is_special && funct == `FN_WRITE_BOTTOM_PRODUCT;
  wire is_signed_product_op = is_special && funct == `FN_SIGNED_PRODUCT_OP;
  wire is_unsigned_product_op = is_special && funct == `FN_UNSIGNED_PRODUCT_OP;
  wire is_div = is_special && (funct == `FN_DIV || funct == `FN_UNSIGNED_QUOTIENT_OP);
  wire is_or = is_special && funct == `FN_OR;
  wire is_nor = is_special && funct == `FN_NOR;
  wire is_sll = is_special && funct == `FN_SLL;
  wire is_ori = instr_valid && opcode == `OP_ORI;
  wire is_sb = instr_valid && opcode == `OP_SB;
  wire is_sh = instr_valid && opcode == `OP_SH;
  wire is_lwr = instr_valid && opcode == `OP_LWR;
  wire is_store = is_sb | is_sh;

  // Effective address for loads and stores
  wire [31:0] ea = primary_val + {{16{imm[15]}}, imm};
  wire half_misaligned = is_sh && ea[0];
  wire [1:0] flip = is_sh ? {user_order_flip, 1'b0} : {2{user_order_flip}};
  wire [1:0] cpu_flip = is_sh ? {cpu_byte_order_big, 1'b0} : {2{cpu_byte_order_big}};
  wire [1:0] lane = ea[1:0] ^ cpu_flip;
  wire [31:0] phys_store = {phys_addr[31:2], phys_addr[1:0] ^ flip};
  wire [31:0] store_data = secondary_val << (`BYTE_SHIFT * lane);
  wire [3:0] store_lanes = is_sh ? (4'h3 << lane) : (4'h1 << lane);

  // Right-part load: type and low address bits follow the merge table
  wire [1:0] lwr_byte = ea[1:0] ^ {2{cpu_byte_order_big}};
  wire [1:0] lwr_phys_low = phys_addr[1:0] ^ {2{user_order_flip}};
  // Little-endian memory takes the full byte offset; big-endian memory a word offset
  wire [2:0] lwr_lem_low = {phys_addr[2], lwr_phys_low} ^ {3{cpu_byte_order_big}};
  wire [2:0] lwr_bem_low = {phys_addr[2] ^ ~cpu_byte_order_big, 2'h0};
  wire [2:0] lwr_low = memory_byte_order_big ? lwr_bem_low : lwr_lem_low;
  wire [31:0] lwr_shifted = load_data >> (`BYTE_SHIFT * lwr_byte);
  wire [31:0] lwr_keep = 32'hffff_ffff >> (`BYTE_SHIFT * lwr_byte);
  wire [31:0] lwr_merge = (lwr_shifted & lwr_keep) | (secondary_val & ~lwr_keep);

  // Result of register-to-register and register-immediate operations
  wire [31:0] sll_val = secondary_val << f_sa;
  wire [31:0] ori_val = {primary_val[31:16], primary_val[15:0] | imm};
  wire [31:0] nor_val = ~(primary_val | secondary_val);
  wire [31:0] or_val = primary_val | secondary_val;
  wire alu_wr = is_sll | is_ori | is_nor | is_or | is_read_upper_product | is_read_bottom_product;
  wire [4:0] alu_dst = is_ori ? f_rt : f_rd;
  wire [31:0] alu_val = is_sll ? sll_val :
                        is_ori ? ori_val :
                        is_nor ? nor_val :
                        is_or ? or_val :
                        is_read_upper_product ? pif.upper : pif.bottom;

  // Exceptions
  wire cop_reserved = is_mfc && unit_no == `COP_RESERVED;
  wire cop_fault = (is_mfc | is_mtc) && !unit_ok && !cop_reserved;
  wire store_tlb = is_store && (tlb_refill | tlb_invalid | tlb_modified | bus_error);
  wire any_exc = cop_reserved | cop_fault | half_misaligned | store_tlb;
  wire ok_mfc = is_mfc && !cop_reserved && unit_ok;
  wire ok_mtc = is_mtc && unit_ok;
  wire ok_store = is_store && !half_misaligned && !store_tlb;

  // Product unit commands
  assign pif.cmd.signed_product_op_s = is_signed_product_op;
  assign pif.cmd.signed_product_op_u = is_unsigned_product_op;
  assign pif.cmd.wr_hi = is_write_upper_product;
  assign pif.cmd.wr_lo = is_write_bottom_product;
  assign pif.cmd.rd_any = is_read_upper_product | is_read_bottom_product;
  assign pif.cmd.other_writer = is_div;
  assign pif.op_a = primary_val;
  assign pif.op_b = secondary_val;

  // Coprocessor read completes in the following stage
  logic mfc_pending;
  logic [4:0] mfc_dst;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mfc_pending <= 1'b0;
      mfc_dst <= 5'h00;
    end else begin
      mfc_pending <= ok_mfc;
      mfc_dst <= f_rt;
    end
  end

  // Coprocessor access, issued one stage after decode
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cop_unit <= 2'h0;
      cop_reg <= 5'h00;
      cop_read <= 1'b0;
      cop_write <= 1'b0;
      cop_write_data <= 32'h0000_0000;
    end else begin
      cop_unit <= unit_no;
      cop_reg <= f_rd;
      cop_read <= ok_mfc;
      cop_write <= ok_mtc;
      cop_write_data <= secondary_val;
    end
  end

  // Register file write port
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      gpr_we <= 1'b0;
      gpr_addr <= 5'h00;
      gpr_data <= 32'h0000_0000;
    end else if (mfc_pending) begin
      gpr_we <= 1'b1;
      gpr_addr <= mfc_dst;
      gpr_data <= cop_read_data;
    end else begin
      gpr_we <= alu_wr | is_lwr;
      gpr_addr <= is_lwr ? f_rt : alu_dst;
      gpr_data <= is_lwr ? lwr_merge : alu_val;
    end
  end

  // Memory request
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_req <= 1'b0;
      mem_write <= 1'b0;
      mem_access <= acc_none;
      mem_type <= 2'h0;
      mem_addr_low <= 3'h0;
      mem_addr <= 32'h0000_0000;
      mem_wdata <= 32'h0000_0000;
      mem_lanes <= 4'h0;
      virt_addr <= 32'h0000_0000;
    end else begin
      mem_req <= ok_store | is_lwr;
      mem_write <= ok_store;
      mem_access <= is_lwr ? acc_lwr : (is_sh ? acc_half : (is_sb ? acc_byte : acc_none));
      mem_type <= is_lwr ? ea[1:0] : (is_sh ? 2'h1 : 2'h0);
      mem_addr_low <= is_lwr ? lwr_low : phys_store[2:0];
      mem_addr <= is_lwr ? {phys_addr[31:3], lwr_low} : phys_store;
      mem_wdata <= store_data;
      mem_lanes <= ok_store ? store_lanes : 4'h0;
      virt_addr <= ea;
    end
  end

  // Exception report
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      exc_valid <= 1'b0;
      exc_code <= exc_none;
      exc_tlb_refill <= 1'b0;
      exc_tlb_invalid <= 1'b0;
      exc_tlb_mod <= 1'b0;
      exc_bus <= 1'b0;
    end else begin
      exc_valid <= any_exc;
      exc_code <= cop_reserved ? exc_reserved : cop_fault ? exc_cop_unusable :
                  half_misaligned ? exc_address : exc_none;
      exc_tlb_refill <= is_store & tlb_refill;
      exc_tlb_invalid <= is_store & tlb_invalid;
      exc_tlb_mod <= is_store & tlb_modified;
      exc_bus <= is_store & bus_error;
    end
  end

  assign product_undefined = pif.result_undefined;
endmodule

// File: bench/exec_unit_props.sv
// Port-level assertions for the execute block
`include "exec_map.svh"
module exec_unit_props (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic instr_valid,
  input wire logic [31:0] instr,
  input wire logic [31:0] primary_val,
  input wire logic [31:0] secondary_val,
  input wire logic [3:0] cop_usable,
  input wire logic [31:0] cop_read_data,
  input wire logic cpu_byte_order_big,
  input wire logic tlb_refill,
  input wire logic tlb_invalid,
  input wire logic tlb_modified,
  input wire logic bus_error,
  input wire logic cop_read,
  input wire logic cop_write,
  input wire logic [31:0] cop_write_data,
  input wire logic gpr_we,
  input wire logic [31:0] gpr_data,
  input wire logic mem_req,
  input wire logic [3:0] mem_lanes,
  input wire logic [31:0] mem_wdata,
  input wire logic exc_valid,
  input wire exec_pkg::exc_code_e exc_code
);
  import exec_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic [31:0] last_i, last_p, last_s;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      last_i <= 32'h0;
      last_p <= 32'h0;
      last_s <= 32'h0;
    end else begin
      last_i <= instr;
      last_p <= primary_val;
      last_s <= secondary_val;
    end
  end
  wire logic [5:0] op = instr[31:26];
  wire logic [5:0] fn = instr[5:0];
  wire logic rtype = instr_valid && op == `OP_SPECIAL;
  wire logic [1:0] unit = instr[27:26];
  wire logic cop_op = instr_valid && instr[31:28] == `OP_COPZ && instr[10:0] == 11'h0;
  wire logic cop_mf = cop_op && instr[25:21] == `SUB_MF;
  wire logic cop_mt = cop_op && instr[25:21] == `SUB_MT;
  wire logic [31:0] ea = primary_val + {{16{instr[15]}}, instr[15:0]};
  wire logic [1:0] lane = ea[1:0] ^ {2{cpu_byte_order_big}};
  wire logic fault = tlb_refill | tlb_invalid | tlb_modified | bus_error;
  a_nor_value: assert property (rtype && fn == `FN_NOR |=> gpr_we && gpr_data == ~(last_p | last_s))
    else $error("nor result wrong");
  a_or_value: assert property (rtype && fn == `FN_OR |=> gpr_we && !exc_valid && gpr_data == (last_p | last_s))
    else $error("or result wrong");
  a_ori_value: assert property (instr_valid && op == `OP_ORI |=> gpr_data == (last_p | {16'h0, last_i[15:0]}))
    else $error("or immediate result wrong");
  a_shift_value: assert property (rtype && fn == `FN_SLL |=> gpr_data == last_s << last_i[10:6])
    else $error("left shift result wrong");
  a_cop_read_path: assert property (cop_mf && unit != `COP_RESERVED && cop_usable[unit]
    |=> cop_read ##1 gpr_we && gpr_data == $past(cop_read_data))
    else $error("coprocessor read path wrong");
  a_cop_reserved: assert property (cop_mf && unit == `COP_RESERVED && cop_usable[3]
    |=> exc_valid && exc_code == exc_reserved && !cop_read)
    else $error("reserved unit not refused");
  a_cop_unusable: assert property ((cop_mf || cop_mt) && unit != `COP_RESERVED && !cop_usable[unit]
    |=> exc_valid && exc_code == exc_cop_unusable && !cop_write && !cop_read)
    else $error("unusable unit not refused");
  a_cop_write_data: assert property (cop_mt && unit != `COP_RESERVED && cop_usable[unit]
    |=> cop_write && cop_write_data == last_s)
    else $error("coprocessor write wrong");
  a_half_odd: assert property (instr_valid && op == `OP_SH && ea[0]
    |=> exc_valid && exc_code == exc_address && !mem_req)
    else $error("odd halfword store not refused");
  a_byte_lane: assert property (instr_valid && op == `OP_SB && !fault
    |=> mem_req && mem_lanes == 4'h1 << $past(lane) && mem_wdata == last_s << (8 * $past(lane)))
    else $error("byte store lane wrong");
  cover property (cop_read ##1 gpr_we);
  cover property (exc_valid && exc_code == exc_address);
  cover property (mem_req && mem_lanes == 4'h3);
endmodule

// File: bench/far_side_model.sv
// Coprocessor register files and memory read word facing the execute block
module far_side_model #(
  parameter logic [31:0] LOAD_WORD = 32'h8899_aabb
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic cop_read,
  input wire logic cop_write,
  input wire logic [1:0] cop_unit,
  input wire logic [4:0] cop_reg,
  input wire logic [31:0] cop_write_data,
  output logic [31:0] cop_read_data,
  output logic [31:0] load_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] regs [128];
  logic [31:0] junk;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      junk <= 32'h5a5a_5a5a;
    end else begin
      junk <= ~junk;
      if (cop_write) begin
        regs[{cop_unit, cop_reg}] <= cop_write_data;
      end
    end
  end
  // Churning pattern whenever no read is shown
  assign cop_read_data = cop_read ? regs[{cop_unit, cop_reg}] : junk;
  assign load_data = LOAD_WORD;
endmodule

// File: bench/exec_unit_tb.sv
// Self-checking bench for the execute block
`include "exec_map.svh"
module exec_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import exec_pkg::*;
  localparam logic [31:0] LOAD_WORD = 32'h8899_aabb;
  logic core_clk = 0, reset_n = 0, instr_valid = 0;
  logic cpu_byte_order_big = 0, user_order_flip = 0, memory_byte_order_big = 0;
  logic [31:0] instr = 0, primary_val = 0, secondary_val = 0, phys_addr = 0;
  logic [3:0] cop_usable = 4'hb, flt = 4'h0;
  logic tlb_refill, tlb_invalid, tlb_modified, bus_error;
  logic [31:0] cop_read_data, load_data, virt_addr, cop_write_data, gpr_data, mem_addr, mem_wdata;
  logic [1:0] cop_unit, mem_type;
  logic [4:0] cop_reg, gpr_addr;
  logic [2:0] mem_addr_low;
  logic [3:0] mem_lanes;
  logic cop_read, cop_write, gpr_we, mem_req, mem_write, exc_valid, product_undefined;
  logic exc_tlb_refill, exc_tlb_invalid, exc_tlb_mod, exc_bus;
  mem_access_e mem_access;
  exc_code_e exc_code;
  int fail_count = 0, samples_checked = 0;
  assign {tlb_refill, tlb_invalid, tlb_modified, bus_error} = flt;
  always #50 core_clk = ~core_clk;
  exec_unit exec_unit_inst (.*);
  far_side_model #(.LOAD_WORD(LOAD_WORD)) far_side_model_inst (.core_clk(core_clk),
    .reset_n(reset_n), .cop_read(cop_read), .cop_write(cop_write), .cop_unit(cop_unit),
    .cop_reg(cop_reg), .cop_write_data(cop_write_data), .cop_read_data(cop_read_data),
    .load_data(load_data));
  function automatic logic [31:0] rr(logic [4:0] rs, rt, rd, sa, logic [5:0] f);
    return {6'h0, rs, rt, rd, sa, f};
  endfunction
  function automatic logic [31:0] ii(logic [5:0] o, logic [4:0] rs, rt, logic [15:0] m);
    return {o, rs, rt, m};
  endfunction
  function automatic logic [31:0] cz(logic [1:0] z, logic [4:0] sub, rt, rd);
    return {`OP_COPZ, z, sub, rt, rd, 11'h0};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Valid stays up so the next call issues back to back
  task automatic issue(input logic [31:0] i, p, s);
    instr = i;
    primary_val = p;
    secondary_val = s;
    instr_valid = 1;
    @(posedge core_clk);
    #1;
  endtask
  task automatic idle(input int n);
    instr_valid = 0;
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic rd_pair(input logic [31:0] hi, lo);
    issue(rr(0, 0, 7, 0, `FN_READ_UPPER_PRODUCT), 0, 0);
    chk("upper", gpr_data, hi);
    issue(rr(0, 0, 8, 0, `FN_READ_BOTTOM_PRODUCT), 0, 0);
    chk("bottom", gpr_data, lo);
    idle(2);
  endtask
  task automatic t_logic;
    issue(rr(1, 2, 3, 0, `FN_NOR), 32'hf0f0_1234, 32'h0ff0_0001);
    chk("nor", gpr_data, 32'h000f_edca);
    issue(rr(1, 2, 4, 0, `FN_OR), 32'h8000_0000, 32'h1);
    chk("or", gpr_data, 32'h8000_0001);
    chk("or_exc", exc_valid, 0);
    issue(ii(`OP_ORI, 1, 5, 16'h8001), 32'h1234_0f00, 0);
    chk("ori", gpr_data, 32'h1234_8f01);
    chk("ori_dst", gpr_addr, 5);
    issue(rr(0, 2, 6, 31, `FN_SLL), 0, 32'h3);
    chk("sll", gpr_data, 32'h8000_0000);
    idle(1);
    $display("logic test done");
  endtask
  task automatic t_product;
    issue(rr(1, 2, 0, 0, `FN_SIGNED_PRODUCT_OP), 32'hffff_fffd, 32'h7);
    idle(2);
    rd_pair(32'hffff_ffff, 32'hffff_ffeb);
    issue(rr(1, 2, 0, 0, `FN_UNSIGNED_PRODUCT_OP), 32'hffff_ffff, 32'h2);
    idle(2);
    rd_pair(32'h1, 32'hffff_fffe);
    chk("defined", product_undefined, 0);
    issue(rr(9, 0, 0, 0, `FN_WRITE_UPPER_PRODUCT), 32'h1111_2222, 0);
    issue(rr(9, 0, 0, 0, `FN_WRITE_BOTTOM_PRODUCT), 32'h3333_4444, 0);
    idle(2);
    rd_pair(32'h1111_2222, 32'h3333_4444);
    issue(rr(1, 2, 0, 0, `FN_SIGNED_PRODUCT_OP), 32'h2, 32'h3);
    issue(rr(9, 0, 0, 0, `FN_WRITE_UPPER_PRODUCT), 32'h5, 0);
    idle(1);
    chk("companion", product_undefined, 1);
    issue(rr(9, 0, 0, 0, `FN_WRITE_BOTTOM_PRODUCT), 32'h6, 0);
    idle(2);
    chk("cleared", product_undefined, 0);
    issue(rr(0, 0, 7, 0, `FN_READ_UPPER_PRODUCT), 0, 0);
    issue(rr(1, 2, 0, 0, `FN_SIGNED_PRODUCT_OP), 32'h2, 32'h3);
    idle(1);
    chk("read_hazard", product_undefined, 1);
    $display("product test done");
  endtask
  task automatic t_cop;
    issue(cz(1, `SUB_MT, 12, 3), 0, 32'hcafe_0001);
    chk("cop_wr", cop_write, 1);
    chk("cop_wdata", cop_write_data, 32'hcafe_0001);
    chk("cop_target", {cop_unit, cop_reg}, 7'h23);
    issue(cz(1, `SUB_MF, 13, 3), 0, 0);
    chk("cop_rd", cop_read, 1);
    idle(1);
    chk("cop_gpr_we", gpr_we, 1);
    chk("cop_gpr", gpr_data, 32'hcafe_0001);
    chk("cop_dst", gpr_addr, 13);
    issue(cz(3, `SUB_MF, 1, 1), 0, 0);
    chk("reserved", exc_code, exc_reserved);
    issue(cz(2, `SUB_MF, 1, 1), 0, 0);
    chk("unusable", exc_code, exc_cop_unusable);
    issue(cz(2, `SUB_MT, 1, 1), 0, 0);
    chk("no_wr", cop_write, 0);
    issue(cz(1, `SUB_MF, 1, 1) | 32'h1, 0, 0);
    chk("low_bits", cop_read, 0);
    idle(1);
    $display("coprocessor test done");
  endtask
  task automatic t_store;
    user_order_flip = 1;
    phys_addr = 32'hff;
    issue(ii(`OP_SB, 1, 2, 16'hffff), 32'h100, 32'h1234_56a5);
    chk("sb_va", virt_addr, 32'hff);
    chk("sb_pa", mem_addr, 32'hfc);
    chk("sb_lanes", mem_lanes, 4'h8);
    chk("sb_data", mem_wdata, 32'ha500_0000);
    cpu_byte_order_big = 1;
    user_order_flip = 0;
    phys_addr = 32'h102;
    issue(ii(`OP_SH, 1, 2, 16'h2), 32'h100, 32'h1234_beef);
    chk("sh_wr", mem_write, 1);
    chk("sh_type", mem_type, 1);
    chk("sh_lanes", mem_lanes, 4'h3);
    chk("sh_data", mem_wdata, 32'h1234_beef);
    phys_addr = 32'h101;
    issue(ii(`OP_SH, 1, 2, 16'h1), 32'h100, 0);
    chk("sh_odd", exc_code, exc_address);
    chk("sh_odd_req", mem_req, 0);
    for (int k = 0; k < 4; k++) begin
      flt = 4'h8 >> k;
      issue(ii(`OP_SB, 1, 2, 16'h0), 32'h100, 0);
      chk("fault", {exc_tlb_refill, exc_tlb_invalid, exc_tlb_mod, exc_bus}, 4'h8 >> k);
    end
    flt = 4'h0;
    idle(1);
    $display("store test done");
  endtask
  task automatic t_lwr;
    cpu_byte_order_big = 0;
    issue(ii(`OP_LWR, 1, 4, 16'h1), 32'h100, 32'h1122_3344);
    chk("lwr_type", mem_type, 1);
    chk("lwr_low", mem_addr_low, 1);
    chk("lwr_merge", gpr_data, {8'h11, LOAD_WORD[31:8]});
    memory_byte_order_big = 1;
    issue(ii(`OP_LWR, 1, 4, 16'h1), 32'h100, 32'h1122_3344);
    chk("lwr_bem_type", mem_type, 1);
    chk("lwr_bem_low", mem_addr_low, 4);
    memory_byte_order_big = 0;
    idle(1);
    $display("right load test done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    #1;
    reset_n = 1;
    t_logic();
    t_product();
    t_cop();
    t_store();
    t_lwr();
    stop_test();
  end
  initial begin
    #200000;
    fail_count++;
    stop_test();
  end
endmodule
bind exec_unit exec_unit_props exec_unit_props_inst (.*);
